// file: hw/acs_seq.v
// How it works
// - Cycle repeats: conversion, then sleep, then data output, forever.
// - Conversion done enters sleep; low power while chip select high.
// - Sleep holds the finished word unchanged in the shift register.
// - Chip select low moves sleep into the data output state.
// - Chip select high before first serial clock rise returns to sleep.
// - After first rise, shifting starts; chip select high aborts, new conversion.
// - Word shipped is from the conversion just finished, one per conversion.
// - Data changes on falling serial clock; host samples on rising edge.
// - Output ends after 24 bits or chip select high after first rise, then converts again.
// - Modes follow pin timing only; no configuration storage alters the cycle.
// - Full-scale calibration runs inside every conversion, timing unchanged.
// - No per-cycle offset calibration phase exists.
// - Low supply holds everything in internal reset.
// - Supply recovery gives a 1 ms reset pulse clearing all registers.
// - After the reset pulse a normal conversion starts.
// - Over and under range give distinct dedicated codes.
// - Clock mode from serial clock level at power up or chip select fall.
// - Data pin floats while chip select high; otherwise shows pending flag, except word bits while shifting.
// - Word: pending flag, low filler, polarity, 21 result bits MSB first.
`include "acs_consts.vh"
`default_nettype none

module acs_seq #(
   parameter [15:0] POR_CYCLES = `ACS_POR_CYCLES,
   parameter [13:0] CONV_LEN = `ACS_CONV_LEN,
   parameter [13:0] CAL_LEN = `ACS_CAL_LEN
) (
   input wire sys_clk,
   input wire rst_n,
   input wire supply_ok,
   input wire cs_n,
   input wire sck_in,
   input wire [20:0] result_mag,
   input wire result_pos,
   input wire over_range,
   input wire under_range,
   output reg sdo_out,
   output reg sdo_oe,
   output reg sck_out,
   output reg sck_oe,
   output reg conv_run,
   output reg fs_cal_run,
   output reg low_power,
   output reg int_reset,
   output reg sck_int_mode,
   output reg word_held
);

   localparam [3:0] ST_POR = 4'h1;
   localparam [3:0] ST_CONV = 4'h2;
   localparam [3:0] ST_SLEEP = 4'h4;
   localparam [3:0] ST_OUT = 4'h8;

   localparam integer CONV_DIV_INT = `ACS_CONV_DIV - 1;
   localparam integer ISCK_HALF_INT = `ACS_ISCK_HALF - 1;
   localparam [8:0] CONV_DIV_LAST = CONV_DIV_INT[8:0];
   localparam [10:0] ISCK_HALF_LAST = ISCK_HALF_INT[10:0];
   localparam [15:0] POR_LAST = POR_CYCLES - 16'h0001;
   localparam [13:0] CONV_LAST = CONV_LEN - 14'h0001;
   localparam [13:0] CAL_FIRST = CONV_LEN - CAL_LEN;

   wire [2:0] sync_q;
   wire supply_s;
   wire cs_s;
   wire sck_s;
   wire sck_eff;
   wire sck_rise;
   wire sck_fall;
   wire cs_fall;
   wire [23:0] new_word;

   reg [3:0] state_r;
   reg [15:0] por_cnt_r;
   reg [8:0] div_cnt_r;
   reg conv_tick_r;
   reg [13:0] conv_cnt_r;
   reg [23:0] shreg_r;
   reg [4:0] bit_cnt_r;
   reg started_r;
   reg sck_eff_d_r;
   reg cs_d_r;
   reg [10:0] isck_cnt_r;

   // Pins come from the host's domain
   acs_sync #(
      .W(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d_in({supply_ok, cs_n, sck_in}),
      .q_out(sync_q)
   );

   assign supply_s = sync_q[2];
   assign cs_s = sync_q[1];
   assign sck_s = sync_q[0];

   // In internal mode the edges are our own generated clock
   assign sck_eff = sck_int_mode ? sck_out : sck_s;
   assign sck_rise = sck_eff & ~sck_eff_d_r;
   assign sck_fall = ~sck_eff & sck_eff_d_r;
   assign cs_fall = cs_d_r & ~cs_s;

   // Range codes take priority over the magnitude
   assign new_word = over_range ? `ACS_OVER_WORD :
                     under_range ? `ACS_UNDER_WORD :
                     {1'b0, 1'b0, result_pos, result_mag};

   // Conversion-clock enable, free running except during internal reset
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt_r <= 9'h000;
         conv_tick_r <= 1'b0;
      end
      else if (!supply_s || state_r == ST_POR)
      begin
         div_cnt_r <= 9'h000;
         conv_tick_r <= 1'b0;
      end
      else if (div_cnt_r == CONV_DIV_LAST)
      begin
         div_cnt_r <= 9'h000;
         conv_tick_r <= 1'b1;
      end
      else
      begin
         div_cnt_r <= div_cnt_r + 9'h001;
         conv_tick_r <= 1'b0;
      end
   end

   // Edge history for chip select and serial clock
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_eff_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end
      else
      begin
         sck_eff_d_r <= sck_eff;
         cs_d_r <= cs_s;
      end
   end

   // Internal serial clock: runs only while bits remain in the word
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         isck_cnt_r <= 11'h000;
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
      end
      else if (!supply_s || !sck_int_mode || state_r != ST_OUT || cs_s)
      begin
         isck_cnt_r <= 11'h000;
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
      end
      else
      begin
         sck_oe <= 1'b1;
         if (isck_cnt_r == ISCK_HALF_LAST)
         begin
            isck_cnt_r <= 11'h000;
            sck_out <= ~sck_out;
         end
         else
         begin
            isck_cnt_r <= isck_cnt_r + 11'h001;
         end
      end
   end

   // Main cycle; no stored configuration exists, only pin timing steers it
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_POR;
         por_cnt_r <= 16'h0000;
         conv_cnt_r <= 14'h0000;
         shreg_r <= 24'h000000;
         bit_cnt_r <= 5'h00;
         started_r <= 1'b0;
         sdo_out <= 1'b1;
         sdo_oe <= 1'b0;
         conv_run <= 1'b0;
         fs_cal_run <= 1'b0;
         low_power <= 1'b0;
         int_reset <= 1'b1;
         sck_int_mode <= 1'b0;
         word_held <= 1'b0;
      end
      else if (!supply_s)
      begin
         // Brown-out keeps the whole block cleared
         state_r <= ST_POR;
         por_cnt_r <= 16'h0000;
         conv_cnt_r <= 14'h0000;
         shreg_r <= 24'h000000;
         bit_cnt_r <= 5'h00;
         started_r <= 1'b0;
         sdo_out <= 1'b1;
         sdo_oe <= 1'b0;
         conv_run <= 1'b0;
         fs_cal_run <= 1'b0;
         low_power <= 1'b0;
         int_reset <= 1'b1;
         sck_int_mode <= 1'b0;
         word_held <= 1'b0;
      end
      else
      begin
         sdo_oe <= ~cs_s;
         if (cs_fall && state_r != ST_POR)
         begin
            sck_int_mode <= sck_s;
         end
         case (state_r)
            ST_POR:
            begin
               // Registers stay clear for the whole pulse
               int_reset <= 1'b1;
               shreg_r <= 24'h000000;
               sdo_out <= 1'b1;
               if (por_cnt_r == POR_LAST)
               begin
                  por_cnt_r <= 16'h0000;
                  int_reset <= 1'b0;
                  sck_int_mode <= sck_s;
                  state_r <= ST_CONV;
                  conv_cnt_r <= 14'h0000;
                  conv_run <= 1'b1;
               end
               else
               begin
                  por_cnt_r <= por_cnt_r + 16'h0001;
               end
            end
            ST_CONV:
            begin
               conv_run <= 1'b1;
               low_power <= 1'b0;
               word_held <= 1'b0;
               sdo_out <= 1'b1;
               bit_cnt_r <= 5'h00;
               started_r <= 1'b0;
               // Gain calibration shares the tail of the same conversion;
               // there is no offset phase, so length stays CONV_LEN
               fs_cal_run <= (conv_cnt_r >= CAL_FIRST);
               if (conv_tick_r)
               begin
                  if (conv_cnt_r == CONV_LAST)
                  begin
                     conv_cnt_r <= 14'h0000;
                     shreg_r <= new_word;
                     state_r <= ST_SLEEP;
                     conv_run <= 1'b0;
                     fs_cal_run <= 1'b0;
                     word_held <= 1'b1;
                     sdo_out <= 1'b0;
                  end
                  else
                  begin
                     conv_cnt_r <= conv_cnt_r + 14'h0001;
                  end
               end
            end
            ST_SLEEP:
            begin
               // Word is untouched here however long the host waits
               low_power <= cs_s;
               sdo_out <= shreg_r[`ACS_PEND_POS];
               if (!cs_s)
               begin
                  state_r <= ST_OUT;
                  low_power <= 1'b0;
                  started_r <= 1'b0;
                  bit_cnt_r <= 5'h00;
               end
            end
            ST_OUT:
            begin
               if (cs_s)
               begin
                  bit_cnt_r <= 5'h00;
                  started_r <= 1'b0;
                  if (!started_r)
                  begin
                     state_r <= ST_SLEEP;
                  end
                  else
                  begin
                     // Abort drops the rest of the word
                     state_r <= ST_CONV;
                     conv_cnt_r <= 14'h0000;
                     conv_run <= 1'b1;
                     word_held <= 1'b0;
                     sdo_out <= 1'b1;
                  end
               end
               else
               begin
                  if (sck_rise && !started_r)
                  begin
                     started_r <= 1'b1;
                  end
                  // Falls before the first rise are an idle clock, not data
                  if (sck_fall && started_r)
                  begin
                     if (bit_cnt_r == `ACS_LAST_BIT)
                     begin
                        bit_cnt_r <= 5'h00;
                        started_r <= 1'b0;
                        state_r <= ST_CONV;
                        conv_cnt_r <= 14'h0000;
                        conv_run <= 1'b1;
                        word_held <= 1'b0;
                        sdo_out <= 1'b1;
                     end
                     else
                     begin
                        shreg_r <= {shreg_r[22:0], 1'b0};
                        sdo_out <= shreg_r[`ACS_FILL_POS];
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                     end
                  end
               end
            end
            default:
            begin
               state_r <= ST_POR;
               por_cnt_r <= 16'h0000;
            end
         endcase
      end
   end

endmodule // acs_seq

`default_nettype wire

// file: include/acs_consts.vh
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// Clock rates
`define ACS_SYS_CLK_HZ 40000000
`define ACS_SYS_CLK_MHZ 40
`define ACS_CONV_CLK_HZ 153600
`define ACS_CONV_DIV (`ACS_SYS_CLK_HZ / `ACS_CONV_CLK_HZ)
`define ACS_ISCK_HZ 19200
`define ACS_ISCK_HALF (`ACS_SYS_CLK_HZ / (2 * `ACS_ISCK_HZ))

// Power-on reset pulse
`define ACS_POR_TIME_US 1000
`define ACS_POR_CYCLES (`ACS_POR_TIME_US * `ACS_SYS_CLK_MHZ)

// Conversion length and calibration tail, in conversion-clock cycles
`define ACS_CONV_LEN 10240
`define ACS_CAL_LEN 512

// Output word layout
`define ACS_WORD_BITS 24
`define ACS_LAST_BIT 5'h17
`define ACS_PEND_POS 23
`define ACS_FILL_POS 22
`define ACS_POL_POS 21
`define ACS_RESULT_BITS 21
`define ACS_OVER_WORD 24'h300000
`define ACS_UNDER_WORD 24'h0fffff

`endif

// file: hw/acs_sync.v
`default_nettype none

module acs_sync #(
   parameter W = 3
) (
   input wire sys_clk,
   input wire rst_n,
   input wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg meta_r;
         reg sync_r;
         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
            end
            else
            begin
               meta_r <= d_in[i];
               sync_r <= meta_r;
            end
         end
         assign q_out[i] = sync_r;
      end
   endgenerate

endmodule // acs_sync

`default_nettype wire

// file: sim/acs_seq_asserts.sv
`default_nettype none
module acs_seq_asserts (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic conv_run,
   input wire logic fs_cal_run,
   input wire logic low_power,
   input wire logic int_reset,
   input wire logic sck_oe,
   input wire logic sck_out,
   input wire logic sck_int_mode,
   input wire logic word_held
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   oe_on_a: assert property ($fell(cs_n) |-> ##[2:4] $rose(sdo_oe))
      else $error("data pin not driven after select");
   oe_off_a: assert property ($rose(cs_n) |-> ##[2:4] $fell(sdo_oe))
      else $error("data pin still driven after deselect");
   por_hold_a: assert property (int_reset |-> !conv_run && !word_held)
      else $error("activity during internal reset");
   sleep_state_a: assert property (low_power |-> word_held && !conv_run)
      else $error("low power outside sleep");
   cal_inside_a: assert property (fs_cal_run |-> conv_run)
      else $error("calibration outside conversion");
   pend_flag_a: assert property (conv_run && $past(conv_run) && sdo_oe |-> sdo_out)
      else $error("pending flag low during conversion");
   conv_end_a: assert property ($fell(conv_run) && !int_reset |-> word_held)
      else $error("conversion end without held word");
   por_len_a: assert property ($fell(int_reset) |-> conv_run && $past(int_reset, 16))
      else $error("reset pulse too short or no conversion");
   sck_mode_a: assert property (sck_oe |-> sck_int_mode)
      else $error("clock driven in external mode");
   cal_every_a: assert property ($fell(conv_run) && !int_reset |-> $past(fs_cal_run))
      else $error("conversion ended without calibration");
   sck_idle_a: assert property (!sck_oe |-> !sck_out)
      else $error("serial clock toggling while not driven");
endmodule // acs_seq_asserts

bind acs_seq acs_seq_asserts chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
   .sdo_out(sdo_out), .sdo_oe(sdo_oe), .conv_run(conv_run), .fs_cal_run(fs_cal_run),
   .low_power(low_power), .int_reset(int_reset), .sck_oe(sck_oe), .sck_out(sck_out),
   .sck_int_mode(sck_int_mode), .word_held(word_held));
`default_nettype wire

// file: sim/acs_host.sv
`default_nettype none
module acs_host (
   output logic cs_n,
   output logic sck,
   input wire logic sdo_out,
   input wire logic sdo_oe,
   input wire logic sck_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last = 1'b0;
   // Released pin shows the inverse, so a stale value never passes
   wire line = sdo_oe ? sdo_out : ~last;
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
   end
   always @(sdo_out or sdo_oe)
      if (sdo_oe)
         last = sdo_out;
   // Clock idles low, so select always latches external mode
   task automatic xfer(input int n, output logic [23:0] w);
      w = 24'h000000;
      cs_n = 1'b0;
      #300;
      for (int i = 0; i < n; i++)
      begin
         sck = 1'b1;
         w = {w[22:0], line};
         #100;
         sck = 1'b0;
         #100;
      end
   endtask
   // Clock held high at select picks internal mode; sample on the device's rises
   task automatic xfer_int(input int n, output logic [23:0] w);
      w = 24'h000000;
      sck = 1'b1;
      #100;
      cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         @(posedge sck_pin);
         w = {w[22:0], line};
      end
      #1;
   endtask
   task automatic release_cs();
      cs_n = 1'b1;
      sck = 1'b0;
      #300;
   endtask
endmodule // acs_host
`default_nettype wire

// file: sim/tb.sv
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic supply_ok = 1'b1;
   logic [23:0] stim = 24'h200000;
   wire cs_n, host_sck, sck_in, sdo_out, sdo_oe, sck_out, sck_oe;
   wire conv_run, fs_cal_run, low_power, int_reset, sck_int_mode, word_held;
   int bad_count = 0;
   int n_tests = 0;
   assign sck_in = sck_oe ? sck_out : host_sck;
   acs_seq #(.POR_CYCLES(16'h0014), .CONV_LEN(14'h0004), .CAL_LEN(14'h0001)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .supply_ok(supply_ok), .cs_n(cs_n),
      .sck_in(sck_in), .result_mag(stim[20:0]), .result_pos(stim[21]),
      .over_range(stim[23]), .under_range(stim[22]), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe), .sck_out(sck_out), .sck_oe(sck_oe), .conv_run(conv_run),
      .fs_cal_run(fs_cal_run), .low_power(low_power), .int_reset(int_reset),
      .sck_int_mode(sck_int_mode), .word_held(word_held));
   acs_host host_u (.cs_n(cs_n), .sck(host_sck), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .sck_pin(sck_in));
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_sleep();
      for (int i = 0; i < 4000 && low_power !== 1'b1; i++)
         tick(1);
   endtask
   task automatic wait_conv();
      for (int i = 0; i < 200 && conv_run !== 1'b1; i++)
         tick(1);
   endtask
   task automatic t_por();
      `CHK(int_reset, 1'b1)
      wait_conv();
      `CHK(int_reset, 1'b0)
      `CHK(sck_int_mode, 1'b0)
      $display("t_por done");
   endtask
   task automatic t_word(input logic [23:0] s, input logic [23:0] exp);
      logic [23:0] w;
      tick(1);
      stim = s;
      wait_sleep();
      `CHK(low_power, 1'b1)
      `CHK(word_held, 1'b1)
      `CHK(sdo_oe, 1'b0)
      host_u.xfer(24, w);
      `CHK(w, exp)
      `CHK(sdo_out, 1'b1)
      tick(8);
      `CHK(conv_run, 1'b1)
      host_u.release_cs();
      $display("t_word %h done", exp);
   endtask
   task automatic t_cancel();
      logic [23:0] w;
      tick(1);
      stim = 24'h255555;
      wait_sleep();
      host_u.xfer(0, w);
      host_u.release_cs();
      stim = 24'h0aaaaa;
      tick(1500);
      `CHK(conv_run, 1'b0)
      `CHK(word_held, 1'b1)
      host_u.xfer(24, w);
      `CHK(w, 24'h255555)
      host_u.release_cs();
      $display("t_cancel done");
   endtask
   task automatic t_int();
      logic [23:0] w;
      tick(1);
      stim = 24'h2abcde;
      wait_sleep();
      host_u.xfer_int(5, w);
      `CHK(sck_int_mode, 1'b1)
      `CHK(sck_oe, 1'b1)
      `CHK(w[4:0], 5'h05)
      host_u.release_cs();
      `CHK(sck_oe, 1'b0)
      `CHK(conv_run, 1'b1)
      $display("t_int done");
   endtask
   task automatic t_abort();
      logic [23:0] w;
      tick(1);
      stim = 24'h3c0f0f;
      wait_sleep();
      host_u.xfer(5, w);
      `CHK(w[4:0], 5'h07)
      host_u.release_cs();
      `CHK(conv_run, 1'b1)
      $display("t_abort done");
   endtask
   task automatic t_supply();
      tick(1);
      wait_sleep();
      supply_ok = 1'b0;
      tick(5);
      `CHK(int_reset, 1'b1)
      `CHK(word_held, 1'b0)
      `CHK(low_power, 1'b0)
      supply_ok = 1'b1;
      wait_conv();
      `CHK(int_reset, 1'b0)
      $display("t_supply done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #2000000;
      bad_count++;
      tally_and_finish();
   end
   initial
   begin
      tick(5);
      rst_n = 1'b1;
      t_por();
      t_word(24'h2abcde, 24'h2abcde);
      t_word(24'h012345, 24'h012345);
      t_word(24'h8abcde, 24'h300000);
      t_word(24'h6abcde, 24'h0fffff);
      t_word(24'hc00000, 24'h300000);
      t_cancel();
      t_int();
      t_abort();
      t_word(24'h3fffff, 24'h3fffff);
      t_supply();
      t_word(24'h100001, 24'h100001);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
